// ---- charger_protection_sequencer.sv ----
// Fault sequencer for the charger front-end protection switch
// What this block does
// - Below lockout: switch off, alarm released
// - Rising above lockout resets all state
// - Wait settle time, then turn on if safe
// - Power-up turn-on ramps gate softly
// - Overvoltage after settle: stay off, alarm
// - Input overvoltage: immediate off, alarm low
// - Recover after hysteresis held for recovery delay
// - Overcurrent starts blanking; brief ones pass
// - Persistent overcurrent: off for retry, then on
// - Count overcurrent trips; fifteenth locks off
// - Power cycle clears counters and lockout
// - Overcurrent turn-off uses soft-stop ramp
// - Battery overvoltage: switch off, alarm low
// - Battery recovery after hysteresis: switch on
// - Count battery faults; fifteenth locks off
// - Battery fault turn-off ramps gate down
// - Overtemperature off; back on after cooling
// - Enable high keeps switch off
// - Disable then enable clears counters, lockout
// - Floating enable reads as enabled
// - Alarm only when enabled and faulted
`timescale 1ns/100ps
module charger_protection_sequencer #(
  parameter int unsigned settle_cycles = prot_pkg::settle_cycles_default,
  parameter int unsigned ov_recovery_cycles = prot_pkg::ov_recovery_cycles_default,
  parameter int unsigned oc_blank_cycles = prot_pkg::oc_blank_cycles_default,
  parameter int unsigned oc_retry_cycles = prot_pkg::oc_retry_cycles_default
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic supply_above_lockout,
  input wire logic input_overvoltage,
  input wire logic input_below_hysteresis,
  input wire logic overcurrent_trip,
  input wire logic battery_overvoltage,
  input wire logic die_overtemperature,
  input wire logic enable_n,
  output logic pass_switch,
  output logic [prot_pkg::ramp_width-1:0] gate_level,
  output logic current_limit_active,
  output logic fault_n_out,
  output logic fault_n_oe,
  output logic [prot_pkg::count_width-1:0] oc_count_out,
  output logic [prot_pkg::count_width-1:0] bat_count_out
);
  import prot_pkg::*;

  // Comparators are free-running analog levels, so each passes two flops
  sync_if cmp ();
  input_sync u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .port(cmp)
  );
  assign cmp.raw = {die_overtemperature, battery_overvoltage, overcurrent_trip,
                    input_below_hysteresis, input_overvoltage, supply_above_lockout};

  logic powered;
  logic in_ov;
  logic in_hys;
  logic oc;
  logic bat_ov;
  logic hot;
  assign powered = cmp.clean[idx_undervoltage_lockout];
  assign in_ov = cmp.clean[idx_in_ov];
  assign in_hys = cmp.clean[idx_in_hys];
  assign oc = cmp.clean[idx_oc];
  assign bat_ov = cmp.clean[idx_bat_ov];
  assign hot = cmp.clean[idx_hot];

  // Enable pin is a plain level; an open pin is pulled low externally
  logic enabled;
  assign enabled = ~enable_n;

  state_type state;
  state_type next_state;
  logic [timer_width-1:0] timer;
  logic [timer_width-1:0] next_timer;
  logic [timer_width-1:0] blank_timer;
  logic [timer_width-1:0] next_blank_timer;
  logic [count_width-1:0] oc_count;
  logic [count_width-1:0] next_oc_count;
  logic [count_width-1:0] bat_count;
  logic [count_width-1:0] next_bat_count;
  logic [ramp_width-1:0] ramp;
  logic [ramp_width-1:0] next_ramp;
  logic next_alarm;
  logic next_limiting;
  logic next_pass_switch;
  logic next_fault_n_oe;

  // Last cycle of each window; every timer counts up from zero
  localparam logic [timer_width-1:0] settle_last = timer_width'(settle_cycles - 1);
  localparam logic [timer_width-1:0] ov_last = timer_width'(ov_recovery_cycles - 1);
  localparam logic [timer_width-1:0] blank_last = timer_width'(oc_blank_cycles - 1);
  localparam logic [timer_width-1:0] retry_last = timer_width'(oc_retry_cycles - 1);
  localparam logic [timer_width-1:0] timer_zero = '0;
  localparam logic [timer_width-1:0] timer_one = timer_width'(1);

  logic oc_expired;
  assign oc_expired = oc && (blank_timer == blank_last);

  always_comb begin
    next_state = state;
    next_timer = timer;
    next_oc_count = oc_count;
    next_bat_count = bat_count;
    if (!powered) begin
      // Held at initial state until supply is above lockout
      next_state = st_settle;
      next_timer = timer_zero;
      next_oc_count = count_zero;
      next_bat_count = count_zero;
    end else if (!enabled) begin
      // Disable clears counters and lockout so re-enable starts fresh
      next_state = st_disabled;
      next_timer = timer_zero;
      next_oc_count = count_zero;
      next_bat_count = count_zero;
    end else begin
      unique case (state)
        st_settle: begin
          // Settle wait restarts on every power-up and every re-enable
          if (timer == settle_last) begin
            next_timer = timer_zero;
            if (in_ov) begin
              next_state = st_ov_wait;
            end else if (bat_ov) begin
              next_state = st_bat_off;
            end else if (hot) begin
              next_state = st_hot_off;
            end else begin
              next_state = st_on;
            end
          end else begin
            next_timer = timer + timer_one;
          end
        end
        st_disabled: begin
          next_state = st_settle;
          next_timer = timer_zero;
        end
        st_on: begin
          // Overvoltage wins; it needs no deglitch
          if (in_ov) begin
            next_state = st_ov_wait;
            next_timer = timer_zero;
          end else if (hot) begin
            next_state = st_hot_off;
          end else if (bat_ov) begin
            next_bat_count = bat_count + count_one;
            next_state = (bat_count + count_one == fault_limit) ? st_locked : st_bat_off;
          end else if (oc_expired) begin
            next_oc_count = oc_count + count_one;
            next_state = (oc_count + count_one == fault_limit) ? st_locked : st_oc_off;
            next_timer = timer_zero;
          end
        end
        st_ov_wait: begin
          // Count only while input sits below the hysteresis level
          if (in_ov || !in_hys) begin
            next_timer = timer_zero;
          end else if (timer == ov_last) begin
            next_state = st_on;
            next_timer = timer_zero;
          end else begin
            next_timer = timer + timer_one;
          end
        end
        st_oc_off: begin
          // Off time runs from a fully discharged gate, after the soft-stop
          if (in_ov) begin
            next_state = st_ov_wait;
            next_timer = timer_zero;
          end else if (hot) begin
            next_state = st_hot_off;
          end else if (ramp != ramp_zero) begin
            next_timer = timer_zero;
          end else if (timer == retry_last) begin
            next_state = st_on;
            next_timer = timer_zero;
          end else begin
            next_timer = timer + timer_one;
          end
        end
        st_bat_off: begin
          // Comparator carries the hysteresis, so its fall is the recovery point
          if (in_ov) begin
            next_state = st_ov_wait;
            next_timer = timer_zero;
          end else if (hot) begin
            next_state = st_hot_off;
          end else if (!bat_ov) begin
            next_state = st_on;
          end
        end
        st_hot_off: begin
          // Comparator releases only below the cooling threshold
          if (in_ov) begin
            next_state = st_ov_wait;
            next_timer = timer_zero;
          end else if (!hot) begin
            next_state = st_on;
          end
        end
        st_locked: begin
          // Only a power cycle or an enable cycle leaves the lockout
          next_state = st_locked;
        end
      endcase
    end
  end

  // Blanking timer runs only while the current limit is engaged
  always_comb begin
    next_blank_timer = timer_zero;
    next_limiting = 1'b0;
    if (powered && enabled && state == st_on && oc) begin
      next_limiting = 1'b1;
      next_blank_timer = oc_expired ? timer_zero : blank_timer + timer_one;
    end
  end

  // Gate ramp: up on each turn-on, down gradually on current or battery trips
  // Follows the state being entered, so a hard cut lands in the same cycle
  always_comb begin
    next_ramp = ramp;
    if (!powered || !enabled || next_state == st_ov_wait || next_state == st_hot_off) begin
      next_ramp = ramp_zero;
    end else if (next_state == st_on) begin
      if (ramp != ramp_full) begin
        next_ramp = ramp + 4'h1;
      end
    end else if (next_state == st_oc_off || next_state == st_bat_off || next_state == st_locked) begin
      if (ramp != ramp_zero) begin
        next_ramp = ramp - 4'h1;
      end
    end else begin
      next_ramp = ramp_zero;
    end
  end

  // Alarm only with supply up and device enabled
  always_comb begin
    next_alarm = 1'b0;
    if (powered && enabled) begin
      unique case (next_state)
        st_ov_wait, st_oc_off, st_bat_off, st_hot_off, st_locked: next_alarm = 1'b1;
        st_settle, st_on, st_disabled: next_alarm = 1'b0;
      endcase
    end
  end

  // Sequencer state, timers, counters and ramp
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= st_settle;
      timer <= '0;
      blank_timer <= '0;
      oc_count <= '0;
      bat_count <= '0;
      ramp <= '0;
    end else begin
      state <= next_state;
      timer <= next_timer;
      blank_timer <= next_blank_timer;
      oc_count <= next_oc_count;
      bat_count <= next_bat_count;
      ramp <= next_ramp;
    end
  end

  // Open drain: oe low sinks the alarm pin, otherwise the pull-up wins
  always_comb begin
    next_pass_switch = (next_ramp != ramp_zero);
    next_fault_n_oe = ~next_alarm;
  end

  // Output flops; oe low means the pin is pulled low
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pass_switch <= 1'b0;
      gate_level <= '0;
      current_limit_active <= 1'b0;
      fault_n_out <= 1'b0;
      fault_n_oe <= 1'b1;
      oc_count_out <= '0;
      bat_count_out <= '0;
    end else begin
      pass_switch <= next_pass_switch;
      gate_level <= next_ramp;
      current_limit_active <= next_limiting;
      fault_n_out <= 1'b0;
      fault_n_oe <= next_fault_n_oe;
      oc_count_out <= next_oc_count;
      bat_count_out <= next_bat_count;
    end
  end
endmodule // charger_protection_sequencer

// ---- prot_pkg.sv ----
// Shared constants and types for the charger protection sequencer
package prot_pkg;
  // Timing figures in clock cycles at 20 MHz; actual durations are parameters of the top
  localparam int unsigned settle_cycles_default = 32'd20000;
  localparam int unsigned ov_recovery_cycles_default = 32'd2000;
  localparam int unsigned oc_blank_cycles_default = 32'd100;
  localparam int unsigned oc_retry_cycles_default = 32'd20000;
  localparam int timer_width = 24;
  localparam int ramp_width = 4;
  localparam logic [ramp_width-1:0] ramp_full = 4'hf;
  localparam logic [ramp_width-1:0] ramp_zero = 4'h0;
  localparam int count_width = 4;
  localparam logic [count_width-1:0] fault_limit = 4'hf;
  localparam logic [count_width-1:0] count_zero = 4'h0;
  localparam logic [count_width-1:0] count_one = 4'h1;
  localparam int sync_stages = 2;
  localparam int comparator_count = 6;
  // Index of each comparator in the synchronised vector
  localparam int idx_undervoltage_lockout = 0;
  localparam int idx_in_ov = 1;
  localparam int idx_in_hys = 2;
  localparam int idx_oc = 3;
  localparam int idx_bat_ov = 4;
  localparam int idx_hot = 5;
  typedef enum logic [2:0] {
    st_settle, st_on, st_ov_wait, st_oc_off, st_bat_off, st_hot_off, st_disabled, st_locked
  } state_type;
endpackage

// ---- sync_if.sv ----
// Interface carrying raw and synchronised comparator results
`timescale 1ns/100ps
interface sync_if;
  import prot_pkg::*;
  logic [comparator_count-1:0] raw;
  logic [comparator_count-1:0] clean;
  modport source (output raw, input clean);
  modport sync (input raw, output clean);
endinterface // sync_if

// ---- input_sync.sv ----
// Two-flop synchroniser bank for the comparator inputs
`timescale 1ns/100ps
module input_sync (
  input wire logic mclk,
  input wire logic sys_rst,
  sync_if.sync port
);
  import prot_pkg::*;
  logic [comparator_count-1:0] stage1;
  logic [comparator_count-1:0] stage2;
  logic [comparator_count-1:0] next_stage1;
  logic [comparator_count-1:0] next_stage2;
  always_comb begin
    next_stage1 = port.raw;
    next_stage2 = stage1;
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end
  assign port.clean = stage2;
endmodule // input_sync

// ---- seq_asserts.sv ----
// Port-level checks for the protection sequencer
`timescale 1ns/100ps
module seq_asserts (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic supply_above_lockout,
  input wire logic input_overvoltage,
  input wire logic die_overtemperature,
  input wire logic enable_n,
  input wire logic pass_switch,
  input wire logic [prot_pkg::ramp_width-1:0] gate_level,
  input wire logic fault_n_out,
  input wire logic fault_n_oe,
  input wire logic [prot_pkg::count_width-1:0] oc_count_out,
  input wire logic [prot_pkg::count_width-1:0] bat_count_out
);
  import prot_pkg::*;
  logic [4:0] quiet;
  logic [4:0] off;
  // Cycles free of hard cuts, and cycles held off
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      quiet <= 5'h0;
      off <= 5'h0;
    end else begin
      quiet <= (input_overvoltage || die_overtemperature || enable_n || !supply_above_lockout) ? 5'h0 :
        (quiet == 5'h1f ? quiet : quiet + 5'h1);
      off <= !(enable_n || !supply_above_lockout) ? 5'h0 : (off == 5'h1f ? off : off + 5'h1);
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Margin covers sync lag plus a full soft-stop
  held_off_a: assert property (off >= 5'h16 |-> !pass_switch && fault_n_oe)
    else $error("switch or alarm while held off");
  ov_cut_a: assert property (input_overvoltage [*4] |-> gate_level == ramp_zero)
    else $error("gate not cut on overvoltage");
  drain_low_a: assert property (fault_n_out == 1'b0)
    else $error("alarm pin drives high");
  soft_start_a: assert property ($rose(pass_switch) |-> gate_level == 4'h1)
    else $error("turn-on skipped the ramp");
  soft_stop_a: assert property (quiet >= 5'h5 && gate_level < $past(gate_level) |->
    gate_level == $past(gate_level) - 4'h1) else $error("gate dropped more than one step");
  oc_step_a: assert property ($changed(oc_count_out) |->
    oc_count_out == $past(oc_count_out) + 4'h1 || oc_count_out == count_zero) else $error("oc count jump");
  bat_step_a: assert property ($changed(bat_count_out) |->
    bat_count_out == $past(bat_count_out) + 4'h1 || bat_count_out == count_zero) else $error("bat count jump");
  oc_lock_a: assert property ($rose(oc_count_out == fault_limit) |-> ##20 !pass_switch)
    else $error("switch on after final trip");
endmodule // seq_asserts
bind charger_protection_sequencer seq_asserts chk (.mclk(mclk), .sys_rst(sys_rst),
  .supply_above_lockout(supply_above_lockout), .input_overvoltage(input_overvoltage),
  .die_overtemperature(die_overtemperature), .enable_n(enable_n), .pass_switch(pass_switch),
  .gate_level(gate_level), .fault_n_out(fault_n_out), .fault_n_oe(fault_n_oe),
  .oc_count_out(oc_count_out), .bat_count_out(bat_count_out));

// ---- host_model.sv ----
// Host side: enable pin driver and pulled-up alarm line
`timescale 1ns/100ps
module host_model (
  input wire logic fault_n_oe,
  output logic enable_n,
  output logic fault_seen
);
  logic drive;
  logic level;
  // External pull-up makes a released pin read high; the pin can only sink
  assign fault_seen = fault_n_oe ? 1'b1 : 1'b0;
  assign enable_n = drive ? level : 1'b0;
  initial begin
    drive = 1'b0;
    level = 1'b0;
  end
  task automatic set_enable(input logic off_req);
    drive = 1'b1;
    level = off_req;
  endtask
endmodule // host_model

// ---- charger_protection_sequencer_tb.sv ----
// Self-checking bench for the protection sequencer
`timescale 1ns/100ps
module charger_protection_sequencer_tb;
  import prot_pkg::*;
  logic mclk, sys_rst, sup, ov, hys, oc, bat, hot;
  logic enable_n, fault_seen, pass_switch, fault_n_out, fault_n_oe, lim;
  logic [ramp_width-1:0] gate_level;
  logic [count_width-1:0] oc_count, bat_count;
  int n_fail, tests_run, m_oc, m_bat;
  always #25 mclk = ~mclk;
  charger_protection_sequencer #(.settle_cycles(8), .ov_recovery_cycles(8), .oc_blank_cycles(4),
    .oc_retry_cycles(8)) dut (.mclk(mclk), .sys_rst(sys_rst), .supply_above_lockout(sup),
    .input_overvoltage(ov), .input_below_hysteresis(hys), .overcurrent_trip(oc), .battery_overvoltage(bat),
    .die_overtemperature(hot), .enable_n(enable_n), .pass_switch(pass_switch), .gate_level(gate_level),
    .current_limit_active(lim), .fault_n_out(fault_n_out), .fault_n_oe(fault_n_oe),
    .oc_count_out(oc_count), .bat_count_out(bat_count));
  host_model host (.fault_n_oe(fault_n_oe), .enable_n(enable_n), .fault_seen(fault_seen));
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #5;
  endtask
  task automatic fail(input string msg);
    n_fail++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask
  task automatic chk_out(input logic sw, input logic line);
    tests_run++;
    if (pass_switch !== sw || fault_seen !== line) fail("switch or alarm line");
  endtask
  task automatic chk_cnt;
    tests_run++;
    if (oc_count !== 4'(m_oc) || bat_count !== 4'(m_bat)) fail("fault counter");
  endtask
  task automatic chk_lim(input logic exp);
    tests_run++;
    if (lim !== exp) fail("current limit flag");
  endtask
  // Alarm wait, or full-gate wait; bounded so a hang shows
  task automatic wait_for(input bit alarm);
    int k;
    k = 0;
    while (!(alarm ? fault_seen === 1'b0 : (pass_switch === 1'b1 && gate_level === ramp_full)) && k < 300) begin
      cyc(1);
      k++;
    end
    if (k == 300) fail("wait ran out");
  endtask
  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    fail("watchdog");
    give_verdict;
  end
  initial begin
    mclk = 1'b0;
    sys_rst = 1'b1;
    {sup, ov, oc, bat, hot} = '0;
    hys = 1'b1;
    n_fail = 0;
    tests_run = 0;
    m_oc = 0;
    m_bat = 0;
    void'($urandom(32'h3e51));
    cyc(4);
    sys_rst = 1'b0;
    cyc(30);
    chk_out(1'b0, 1'b1);
    sup = 1'b1;
    wait_for(1'b0);
    chk_out(1'b1, 1'b1);
    $display("test power up done");
    ov = 1'b1;
    hys = 1'b0;
    cyc(5);
    chk_out(1'b0, 1'b0);
    ov = 1'b0;
    hys = 1'b1;
    cyc(8);
    chk_out(1'b0, 1'b0);
    wait_for(1'b0);
    chk_out(1'b1, 1'b1);
    $display("test overvoltage done");
    oc = 1'b1;
    cyc(3);
    chk_lim(1'b1);
    oc = 1'b0;
    cyc(10);
    chk_lim(1'b0);
    chk_out(1'b1, 1'b1);
    chk_cnt;
    for (int i = 0; i < 15; i++) begin
      oc = 1'b1;
      wait_for(1'b1);
      m_oc++;
      oc = 1'b0;
      cyc(1);
      chk_cnt;
      if (i < 14) wait_for(1'b0);
    end
    cyc(40);
    chk_out(1'b0, 1'b0);
    host.set_enable(1'b1);
    cyc(30);
    chk_out(1'b0, 1'b1);
    host.set_enable(1'b0);
    m_oc = 0;
    wait_for(1'b0);
    chk_cnt;
    $display("test overcurrent done");
    for (int i = 0; i < 15; i++) begin
      bat = 1'b1;
      wait_for(1'b1);
      m_bat++;
      cyc($urandom_range(6, 1));
      bat = 1'b0;
      chk_cnt;
      if (i < 14) wait_for(1'b0);
    end
    cyc(40);
    chk_out(1'b0, 1'b0);
    sup = 1'b0;
    cyc(30);
    chk_out(1'b0, 1'b1);
    sup = 1'b1;
    m_bat = 0;
    wait_for(1'b0);
    chk_cnt;
    $display("test battery done");
    hot = 1'b1;
    cyc(25);
    chk_out(1'b0, 1'b0);
    hot = 1'b0;
    wait_for(1'b0);
    chk_out(1'b1, 1'b1);
    sup = 1'b0;
    cyc(10);
    ov = 1'b1;
    hys = 1'b0;
    sup = 1'b1;
    cyc(40);
    chk_out(1'b0, 1'b0);
    $display("test thermal and early overvoltage done");
    give_verdict;
  end
endmodule // charger_protection_sequencer_tb
